// ==== core/anh_pkg.sv ====
// Purpose: Shared constants and types for the auto-negotiation host controller
// Assumes: 25 MHz system clock, PHY reached over the MII management pins
// Notes: Avalon offsets are byte addresses, each register one aligned word
package anh_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MDC_MIN_PERIOD_NS = 400;
  localparam int MDC_HALF_CYC =
    (MDC_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

  // PHY management register numbers
  localparam logic [4:0] PHY_REG_CTRL = 5'h00;
  localparam logic [4:0] PHY_REG_STAT = 5'h01;
  localparam logic [4:0] PHY_REG_ADV = 5'h04;
  localparam logic [4:0] PHY_REG_PARTNER = 5'h05;
  localparam logic [4:0] PHY_REG_EXP = 5'h06;
  localparam logic [4:0] PHY_REG_NPTX = 5'h07;

  // PHY register bit positions
  localparam int CTL_SPEED = 13;
  localparam int CTL_ENABLE = 12;
  localparam int CTL_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int STAT_COMPLETE = 5;
  localparam int STAT_RFAULT = 4;
  localparam int STAT_AN_ABLE = 3;
  localparam int ADV_NP = 15;
  localparam int ADV_RF = 13;
  localparam int ADV_ABIL_W = 13;
  localparam int EXP_PAGE_RX = 1;

  // Page layout
  localparam int PG_MORE = 15;
  localparam int PG_ACK = 14;
  localparam int PG_KIND = 13;
  localparam int PG_COMPLY = 12;
  localparam int PG_TOGGLE = 11;
  localparam int PG_CODE_W = 11;
  localparam logic [10:0] NULL_MSG_DEF = 11'h001;
  localparam logic [10:0] MSG_MAX_DEF = 11'h00f;

  // Management frame
  localparam logic [5:0] FRAME_LAST = 6'h3f;
  localparam logic [5:0] TA_IDX = 6'h2e;
  localparam logic [5:0] DATA_IDX = 6'h30;
  localparam logic [31:0] PREAMBLE = 32'hffff_ffff;
  localparam logic [1:0] FR_START = 2'b01;
  localparam logic [1:0] FR_OP_RD = 2'b10;
  localparam logic [1:0] FR_OP_WR = 2'b01;
  localparam logic [1:0] FR_TA_WR = 2'b10;

  // Avalon word indices (byte address / 4)
  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_ADV = 3'h1;
  localparam logic [2:0] A_PAGE = 3'h2;
  localparam logic [2:0] A_STATUS = 3'h3;
  localparam logic [2:0] A_PARTNER = 3'h4;
  localparam logic [2:0] A_PHYAD = 3'h5;
  localparam logic [2:0] A_PBASE = 3'h6;

  // Avalon field positions
  localparam int C_EN = 0;
  localparam int C_SPEED = 1;
  localparam int C_DUPLEX = 2;
  localparam int C_FAULT = 3;
  localparam int C_NP = 4;
  localparam int C_START = 5;
  localparam int C_W = 5;
  localparam int P_KIND = 11;
  localparam int P_COMPLY = 12;
  localparam int P_MORE = 13;
  localparam int P_W = 14;
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_RFAULT = 2;
  localparam int S_PEND = 3;
  localparam int S_NPACT = 4;
  localparam int S_CODEERR = 5;
  localparam int S_ANABLE = 6;
  localparam int S_PMORE = 7;
  localparam int S_WAITPG = 8;

  typedef enum {
    ST_IDLE, ST_CHK, ST_ADV, ST_CTRL, ST_RST, ST_POLL, ST_EXP, ST_LP, ST_NPWR
  } anh_state_e;
endpackage

// ==== core/anh_page.sv ====
// Purpose: Builds a next page word and checks its code field
// Assumes: Pure combinational, acknowledge left to the PHY
// Notes: Message codes outside 1..code_max are refused
`timescale 1ns/1ps
module anh_page (
  input wire logic [10:0] code_i,
  input wire logic kind_i,
  input wire logic comply_i,
  input wire logic more_i,
  input wire logic toggle_i,
  input wire logic [10:0] code_max_i,
  output logic [15:0] page_o,
  output logic code_ok_o
);
  always_comb begin
    page_o = '0;
    page_o[anh_pkg::PG_CODE_W-1:0] = code_i;
    page_o[anh_pkg::PG_TOGGLE] = toggle_i;
    page_o[anh_pkg::PG_COMPLY] = comply_i;
    page_o[anh_pkg::PG_KIND] = kind_i;
    page_o[anh_pkg::PG_ACK] = 1'b0;
    page_o[anh_pkg::PG_MORE] = more_i;
  end

  // Unformatted payload is free; message codes must be assigned ones
  assign code_ok_o = ~kind_i | ((code_i != '0) & (code_i <= code_max_i));
endmodule

// ==== core/anh_mdio.sv ====
// Purpose: Management frame engine driving MDC and MDIO
// Assumes: MDC made here by dividing the system clock
// Notes: Data changes after MDC falls, read bits taken just before MDC rises
`timescale 1ns/1ps
module anh_mdio (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic start_i,
  input wire logic rd_i,
  input wire logic [4:0] phyad_i,
  input wire logic [4:0] regad_i,
  input wire logic [15:0] wdata_i,
  input wire logic mdio_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  localparam logic [3:0] HALF_LAST = 4'(anh_pkg::MDC_HALF_CYC - 1);

  logic mdio_meta_ff, mdio_sync_ff;
  logic busy_ff, mdc_ff, rd_ff, done_ff;
  logic [5:0] bit_ff;
  logic [3:0] ph_ff;
  logic [63:0] sh_ff;
  logic [15:0] rdata_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mdio_meta_ff <= 1'b1;
      mdio_sync_ff <= 1'b1;
    end else if (en_i) begin
      mdio_meta_ff <= mdio_i;
      mdio_sync_ff <= mdio_meta_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      mdc_ff <= 1'b0;
      rd_ff <= 1'b0;
      done_ff <= 1'b0;
      bit_ff <= '0;
      ph_ff <= '0;
      sh_ff <= '0;
      rdata_ff <= '0;
    end else if (en_i) begin
      done_ff <= 1'b0;
      if (!busy_ff) begin
        if (start_i) begin
          busy_ff <= 1'b1;
          rd_ff <= rd_i;
          bit_ff <= '0;
          ph_ff <= '0;
          mdc_ff <= 1'b0;
          sh_ff <= {anh_pkg::PREAMBLE, anh_pkg::FR_START,
                    rd_i ? anh_pkg::FR_OP_RD : anh_pkg::FR_OP_WR,
                    phyad_i, regad_i, anh_pkg::FR_TA_WR, rd_i ? 16'h0000 : wdata_i};
        end
      end else begin
        if (ph_ff == HALF_LAST) begin
          ph_ff <= '0;
          mdc_ff <= ~mdc_ff;
          if (mdc_ff) begin
            bit_ff <= bit_ff + 6'h01;
            sh_ff <= {sh_ff[62:0], 1'b0};
            if (bit_ff == anh_pkg::FRAME_LAST) begin
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
            end
          end else if (rd_ff && bit_ff >= anh_pkg::DATA_IDX) begin
            rdata_ff <= {rdata_ff[14:0], mdio_sync_ff};
          end
        end else begin
          ph_ff <= ph_ff + 4'h1;
        end
      end
    end
  end

  assign done_o = done_ff;
  assign rdata_o = rdata_ff;
  assign mdc_o = mdc_ff;
  assign mdio_o = sh_ff[63];
  assign mdio_oe_o = busy_ff & (~rd_ff | (bit_ff < anh_pkg::TA_IDX));
endmodule

// ==== core/anh_host.sv ====
// Purpose: Station-side controller running auto-negotiation and next page exchange
// Assumes: One PHY on the management pins, Avalon-MM slave with waitrequest
// Notes: Software queues next pages one at a time; a null message goes out when none is queued and none was promised
// How it works
// - Each sent page carries the more-pages flag software gave, null pages send zero.
// - Page-kind flag is high for message pages and low for unformatted ones.
// - Comply flag is taken from software for each queued page.
// - Toggle bit of each page is the inverse of the previous one sent.
// - First next page toggle is the inverse of base codeword bit eleven.
// - Message pages with unassigned codes are refused at the register port.
// - Unformatted pages keep the five control bits; payload is free.
// - Next pages start only when both base codewords advertise next page ability.
// - At least one next page is sent once exchange begins.
// - Exchange runs until neither side sets more pages; null messages fill in.
// - Unformatted pages are accepted only right after a queued page, of either kind, asking for more.
// - Restart is written zero when the PHY reports no negotiation ability.
// - Page bits: code 10..0, toggle 11, comply 12, kind 13, ack 14, more 15.
// - After our own pages end, null message pages with more-pages low follow.
`timescale 1ns/1ps
module anh_host #(
  parameter logic [10:0] NULL_MSG_CODE = anh_pkg::NULL_MSG_DEF,
  parameter logic [10:0] MSG_CODE_MAX = anh_pkg::MSG_MAX_DEF
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic MDC_O,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE_O
);
  anh_pkg::anh_state_e state_ff;

  logic [2:0] idx;
  logic req, ack_ff, wr_acc, rd_acc;
  logic [31:0] rd_word, rdata_ff;
  logic start_ff;
  logic [anh_pkg::C_W-1:0] ctrl_ff;
  logic [anh_pkg::ADV_ABIL_W-1:0] adv_ff;
  logic [4:0] phyad_ff;
  logic [anh_pkg::P_W-1:0] page_ff;
  logic pend_ff, unf_ok_ff, code_err_ff, rf_seen_ff, rf_hold_ff;
  logic [15:0] partner_ff, pbase_ff;
  logic an_able_ff, complete_ff, last_tog_ff, local_more_ff, sent_one_ff;
  logic base_seen_ff, partner_more_ff, np_active_ff, mwait_ff, take_ff, tx_more_ff;
  logic sw_code_ok, page_wr, page_ok, stall, mstart, mrd, mdone;
  logic [4:0] mreg;
  logic [15:0] mwdata, mrdata, ctl_word, adv_word, tx_page;
  logic [10:0] tx_code;
  logic tx_kind, tx_comply, tx_more, comp_evt, rf_evt, status_rd;

  // Avalon slave: one wait cycle, read data registered at the edge that drops waitrequest, effect one edge later
  assign idx = AVS_ADDRESS_I[4:2];
  assign req = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = req & ~(ack_ff & CE_I);
  assign wr_acc = AVS_WRITE_I & ack_ff & CE_I;
  assign rd_acc = AVS_READ_I & ack_ff & CE_I;
  assign status_rd = rd_acc & (idx == anh_pkg::A_STATUS);
  assign AVS_READDATA_O = rdata_ff;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
    end else if (CE_I) begin
      ack_ff <= req & ~ack_ff;
      if (AVS_READ_I && !ack_ff) begin
        rdata_ff <= rd_word;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    case (idx)
      anh_pkg::A_CTRL: rd_word[anh_pkg::C_W-1:0] = ctrl_ff;
      anh_pkg::A_ADV: rd_word[anh_pkg::ADV_ABIL_W-1:0] = adv_ff;
      anh_pkg::A_PAGE: rd_word[anh_pkg::P_W-1:0] = page_ff;
      anh_pkg::A_STATUS: begin
        rd_word[anh_pkg::S_BUSY] = state_ff != anh_pkg::ST_IDLE;
        rd_word[anh_pkg::S_DONE] = complete_ff;
        rd_word[anh_pkg::S_RFAULT] = rf_seen_ff;
        rd_word[anh_pkg::S_PEND] = pend_ff;
        rd_word[anh_pkg::S_NPACT] = np_active_ff;
        rd_word[anh_pkg::S_CODEERR] = code_err_ff;
        rd_word[anh_pkg::S_ANABLE] = an_able_ff;
        rd_word[anh_pkg::S_PMORE] = partner_more_ff;
        rd_word[anh_pkg::S_WAITPG] = stall & (state_ff == anh_pkg::ST_NPWR);
      end
      anh_pkg::A_PARTNER: rd_word[15:0] = partner_ff;
      anh_pkg::A_PHYAD: rd_word[4:0] = phyad_ff;
      anh_pkg::A_PBASE: rd_word[15:0] = pbase_ff;
      default: rd_word = '0;
    endcase
  end

  // Software configuration
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ctrl_ff <= '0;
      adv_ff <= '0;
      phyad_ff <= '0;
      start_ff <= 1'b0;
    end else if (CE_I) begin
      start_ff <= wr_acc & (idx == anh_pkg::A_CTRL) & AVS_WRITEDATA_I[anh_pkg::C_START];
      if (wr_acc && idx == anh_pkg::A_CTRL) begin
        ctrl_ff <= AVS_WRITEDATA_I[anh_pkg::C_W-1:0];
      end
      if (wr_acc && idx == anh_pkg::A_ADV) begin
        adv_ff <= AVS_WRITEDATA_I[anh_pkg::ADV_ABIL_W-1:0];
      end
      if (wr_acc && idx == anh_pkg::A_PHYAD) begin
        phyad_ff <= AVS_WRITEDATA_I[4:0];
      end
    end
  end

  // Page queue of one entry, checked on entry
  anh_page u_check (
    .code_i(AVS_WRITEDATA_I[anh_pkg::PG_CODE_W-1:0]),
    .kind_i(AVS_WRITEDATA_I[anh_pkg::P_KIND]),
    .comply_i(AVS_WRITEDATA_I[anh_pkg::P_COMPLY]),
    .more_i(AVS_WRITEDATA_I[anh_pkg::P_MORE]),
    .toggle_i(1'b0),
    .code_max_i(MSG_CODE_MAX),
    .page_o(),
    .code_ok_o(sw_code_ok)
  );

  assign page_wr = wr_acc & (idx == anh_pkg::A_PAGE);
  assign page_ok = ~pend_ff & sw_code_ok
                 & (AVS_WRITEDATA_I[anh_pkg::P_KIND] | unf_ok_ff);

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      page_ff <= '0;
      pend_ff <= 1'b0;
      unf_ok_ff <= 1'b0;
    end else if (CE_I) begin
      if (page_wr && page_ok) begin
        page_ff <= AVS_WRITEDATA_I[anh_pkg::P_W-1:0];
        pend_ff <= 1'b1;
        unf_ok_ff <= AVS_WRITEDATA_I[anh_pkg::P_MORE];
      end else if (state_ff == anh_pkg::ST_NPWR && mdone && take_ff) begin
        pend_ff <= 1'b0;
      end
      if (start_ff && state_ff == anh_pkg::ST_IDLE) begin
        unf_ok_ff <= 1'b0;
      end
    end
  end

  // Sticky flags; a new event beats the clear caused by a status read
  assign comp_evt = (state_ff == anh_pkg::ST_POLL) & mdone & mrdata[anh_pkg::STAT_COMPLETE];
  assign rf_evt = mdone & mrd & (mreg == anh_pkg::PHY_REG_STAT)
                & mrdata[anh_pkg::STAT_RFAULT];

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      code_err_ff <= 1'b0;
      rf_seen_ff <= 1'b0;
      rf_hold_ff <= 1'b0;
    end else if (CE_I) begin
      code_err_ff <= (page_wr & ~page_ok)
                   | (code_err_ff & ~(status_rd & rdata_ff[anh_pkg::S_CODEERR]));
      rf_seen_ff <= rf_evt | (rf_seen_ff & ~(status_rd & rdata_ff[anh_pkg::S_RFAULT]));
      rf_hold_ff <= ctrl_ff[anh_pkg::C_FAULT] | (rf_hold_ff & ~comp_evt);
    end
  end

  // Words written to the PHY
  always_comb begin
    ctl_word = '0;
    ctl_word[anh_pkg::CTL_ENABLE] = ctrl_ff[anh_pkg::C_EN];
    ctl_word[anh_pkg::CTL_SPEED] = ctrl_ff[anh_pkg::C_SPEED];
    ctl_word[anh_pkg::CTL_DUPLEX] = ctrl_ff[anh_pkg::C_DUPLEX];
    ctl_word[anh_pkg::CTL_RESTART] = ctrl_ff[anh_pkg::C_EN] & an_able_ff;
    adv_word = '0;
    adv_word[anh_pkg::ADV_ABIL_W-1:0] = adv_ff;
    adv_word[anh_pkg::ADV_RF] = rf_hold_ff | ctrl_ff[anh_pkg::C_FAULT];
    adv_word[anh_pkg::ADV_NP] = ctrl_ff[anh_pkg::C_NP];
  end

  // Queued page, or a null message with more-pages low once ours are done
  assign tx_code = pend_ff ? page_ff[anh_pkg::PG_CODE_W-1:0] : NULL_MSG_CODE;
  assign tx_kind = pend_ff ? page_ff[anh_pkg::P_KIND] : 1'b1;
  assign tx_comply = pend_ff & page_ff[anh_pkg::P_COMPLY];
  assign tx_more = pend_ff & page_ff[anh_pkg::P_MORE];

  anh_page u_tx (
    .code_i(tx_code),
    .kind_i(tx_kind),
    .comply_i(tx_comply),
    .more_i(tx_more),
    .toggle_i(~last_tog_ff),
    .code_max_i(MSG_CODE_MAX),
    .page_o(tx_page),
    .code_ok_o()
  );

  // Having promised more pages, wait for software rather than send a filler
  assign stall = ~pend_ff & local_more_ff;

  always_comb begin
    mrd = 1'b1;
    mreg = anh_pkg::PHY_REG_STAT;
    mwdata = '0;
    unique case (state_ff)
      anh_pkg::ST_IDLE, anh_pkg::ST_CHK, anh_pkg::ST_POLL: mreg = anh_pkg::PHY_REG_STAT;
      anh_pkg::ST_ADV: begin
        mrd = 1'b0;
        mreg = anh_pkg::PHY_REG_ADV;
        mwdata = adv_word;
      end
      anh_pkg::ST_CTRL: begin
        mrd = 1'b0;
        mreg = anh_pkg::PHY_REG_CTRL;
        mwdata = ctl_word;
      end
      anh_pkg::ST_RST: mreg = anh_pkg::PHY_REG_CTRL;
      anh_pkg::ST_EXP: mreg = anh_pkg::PHY_REG_EXP;
      anh_pkg::ST_LP: mreg = anh_pkg::PHY_REG_PARTNER;
      anh_pkg::ST_NPWR: begin
        mrd = 1'b0;
        mreg = anh_pkg::PHY_REG_NPTX;
        mwdata = tx_page;
      end
    endcase
  end

  assign mstart = (state_ff != anh_pkg::ST_IDLE) & ~mwait_ff
                & ~((state_ff == anh_pkg::ST_NPWR) & stall);

  anh_mdio u_mdio (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .en_i(CE_I),
    .start_i(mstart),
    .rd_i(mrd),
    .phyad_i(phyad_ff),
    .regad_i(mreg),
    .wdata_i(mwdata),
    .mdio_i(MDIO_I),
    .done_o(mdone),
    .rdata_o(mrdata),
    .mdc_o(MDC_O),
    .mdio_o(MDIO_O),
    .mdio_oe_o(MDIO_OE_O)
  );

  // Negotiation sequencer
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state_ff <= anh_pkg::ST_IDLE;
      mwait_ff <= 1'b0;
      an_able_ff <= 1'b0;
      complete_ff <= 1'b0;
      last_tog_ff <= 1'b0;
      local_more_ff <= 1'b0;
      sent_one_ff <= 1'b0;
      base_seen_ff <= 1'b0;
      partner_more_ff <= 1'b0;
      np_active_ff <= 1'b0;
      take_ff <= 1'b0;
      tx_more_ff <= 1'b0;
      partner_ff <= '0;
      pbase_ff <= '0;
    end else if (CE_I) begin
      if (mstart) begin
        mwait_ff <= 1'b1;
        take_ff <= pend_ff;
        tx_more_ff <= tx_more;
      end else if (mdone) begin
        mwait_ff <= 1'b0;
      end
      unique case (state_ff)
        anh_pkg::ST_IDLE: begin
          if (start_ff) begin
            state_ff <= anh_pkg::ST_CHK;
            complete_ff <= 1'b0;
            local_more_ff <= 1'b0;
            sent_one_ff <= 1'b0;
            base_seen_ff <= 1'b0;
            np_active_ff <= 1'b0;
          end
        end
        anh_pkg::ST_CHK: begin
          if (mdone) begin
            an_able_ff <= mrdata[anh_pkg::STAT_AN_ABLE];
            state_ff <= anh_pkg::ST_ADV;
          end
        end
        anh_pkg::ST_ADV: begin
          if (mdone) begin
            last_tog_ff <= adv_word[anh_pkg::PG_TOGGLE];
            state_ff <= anh_pkg::ST_CTRL;
          end
        end
        anh_pkg::ST_CTRL: begin
          if (mdone) begin
            state_ff <= ctl_word[anh_pkg::CTL_RESTART] ? anh_pkg::ST_RST
                                                       : anh_pkg::ST_IDLE;
          end
        end
        anh_pkg::ST_RST: begin
          if (mdone && !mrdata[anh_pkg::CTL_RESTART]) begin
            state_ff <= anh_pkg::ST_POLL;
          end
        end
        anh_pkg::ST_POLL: begin
          if (comp_evt) begin
            complete_ff <= 1'b1;
            np_active_ff <= 1'b0;
            state_ff <= anh_pkg::ST_IDLE;
          end else if (mdone) begin
            state_ff <= anh_pkg::ST_EXP;
          end
        end
        anh_pkg::ST_EXP: begin
          if (mdone) begin
            state_ff <= mrdata[anh_pkg::EXP_PAGE_RX] ? anh_pkg::ST_LP : anh_pkg::ST_POLL;
          end
        end
        anh_pkg::ST_LP: begin
          if (mdone) begin
            partner_more_ff <= mrdata[anh_pkg::PG_MORE];
            if (!base_seen_ff) begin
              base_seen_ff <= 1'b1;
              pbase_ff <= mrdata;
              if (ctrl_ff[anh_pkg::C_NP] && mrdata[anh_pkg::ADV_NP]) begin
                np_active_ff <= 1'b1;
                state_ff <= anh_pkg::ST_NPWR;
              end else begin
                state_ff <= anh_pkg::ST_POLL;
              end
            end else begin
              partner_ff <= mrdata;
              if (local_more_ff || mrdata[anh_pkg::PG_MORE] || !sent_one_ff) begin
                state_ff <= anh_pkg::ST_NPWR;
              end else begin
                state_ff <= anh_pkg::ST_POLL;
              end
            end
          end
        end
        anh_pkg::ST_NPWR: begin
          if (mdone) begin
            last_tog_ff <= ~last_tog_ff;
            local_more_ff <= tx_more_ff;
            sent_one_ff <= 1'b1;
            state_ff <= anh_pkg::ST_POLL;
          end
        end
      endcase
    end
  end
endmodule

// ==== verif/anh_host_assertions.sv ====
// Purpose: Port assertions for the auto-negotiation host
// Assumes: CE_I held high by the bench
// Notes: Bound to every anh_host instance
`timescale 1ns/1ps
module anh_chk (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic MDC_O,
  input wire logic MDIO_I,
  input wire logic MDIO_O,
  input wire logic MDIO_OE_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  property p_nw; !(AVS_READ_I || AVS_WRITE_I) |-> !AVS_WAITREQUEST_O; endproperty
  a_nw: assert property (p_nw) else $error("wait without request");
  property p_an;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && CE_I |=> !AVS_WAITREQUEST_O;
  endproperty
  a_an: assert property (p_an) else $error("no answer");
  property p_hi; $rose(MDC_O) |-> MDC_O [*5] ##1 !MDC_O; endproperty
  a_hi: assert property (p_hi) else $error("clock high phase");
  property p_lo; $fell(MDC_O) |-> !MDC_O [*5]; endproperty
  a_lo: assert property (p_lo) else $error("clock low phase");
  property p_chg; $changed(MDIO_O) |-> !MDC_O; endproperty
  a_chg: assert property (p_chg) else $error("data moved while clock high");
  property p_pre; $rose(MDIO_OE_O) |-> MDIO_O && !MDC_O; endproperty
  a_pre: assert property (p_pre) else $error("frame start");
  property p_unm;
    AVS_READ_I && AVS_ADDRESS_I[4:2] == 3'h7 && !AVS_WAITREQUEST_O |-> AVS_READDATA_O == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_rs;
    AVS_READ_I && AVS_ADDRESS_I[4:2] == 3'h0 && !AVS_WAITREQUEST_O |-> !AVS_READDATA_O[5];
  endproperty
  a_rs: assert property (p_rs) else $error("start bit read as one");
endmodule
bind anh_host anh_chk anh_chk_i (.CLK_SYS_I, .RST_I, .CE_I, .AVS_ADDRESS_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .MDC_O, .MDIO_I,
  .MDIO_O, .MDIO_OE_O);

// ==== verif/anh_phy_model.sv ====
// Purpose: Behavioural PHY answering management frames
// Assumes: Any PHY address, pull-up on the data line
// Notes: Partner answers each of our pages with one null message page
`timescale 1ns/1ps
module anh_phy_model (
  input wire logic mdc_i,
  input wire logic mdio_i,
  input wire logic able_i,
  input wire logic [15:0] base_i,
  output logic mdio_o,
  output logic mdio_oe_o
);
  logic [15:0] r [0:7];
  logic [15:0] pg [0:7];
  logic [15:0] sr = 16'hffff;
  logic [15:0] d = 16'h0;
  logic [2:0] ra = 3'h0;
  logic on = 1'b0;
  logic rdop = 1'b0;
  logic pt = 1'b0;
  int k = 0;
  int npg = 0;
  initial begin
    foreach (r[i]) r[i] = 16'h0;
    mdio_o = 1'b0;
    mdio_oe_o = 1'b0;
  end
  task automatic start_an();
    r[1][5] = !(r[4][15] && base_i[15]);
    r[1][4] = base_i[13];
    r[5] = base_i;
    r[6][1] = 1'b1;
    pt = base_i[11];
    npg = 0;
  endtask
  task automatic wr_side(input logic [15:0] v);
    if (ra == 3'h1 || ra == 3'h5 || ra == 3'h6) return;
    r[ra] = v;
    if (ra == 3'h0) begin
      r[0][9] = v[9] && v[12] && able_i;
      if (!v[12]) r[1][5] = 1'b0;
    end
    if (ra == 3'h7) begin
      pg[npg] = v;
      npg++;
      pt = !pt;
      r[5] = {4'h6, pt, 11'h001};
      r[6][1] = 1'b1;
    end
  endtask
  always @(posedge mdc_i) begin
    sr = {sr[14:0], mdio_i};
    k = k + 1;
    if (!on && sr[1:0] == 2'b10) begin
      on = 1'b1;
      k = 0;
    end
    if (on && k == 13) begin
      rdop = sr[11:10] == 2'b10;
      ra = sr[2:0];
      r[1][3] = able_i;
      d = r[ra];
      if (rdop && ra == 3'h0 && r[0][9]) begin
        r[0][9] = 1'b0;
        start_an();
      end
      if (rdop && ra == 3'h1) r[1][4] = 1'b0;
      if (rdop && ra == 3'h6) r[6][1] = 1'b0;
      if (rdop && ra == 3'h5 && npg > 0 && !pg[npg - 1][15]) r[1][5] = 1'b1;
    end
    if (on && k == 31) begin
      if (!rdop) wr_side(sr);
      on = 1'b0;
      mdio_oe_o = 1'b0;
      sr = 16'hffff;
    end
  end
  always @(negedge mdc_i) begin
    if (on && rdop && k >= 14) begin
      mdio_oe_o = 1'b1;
      mdio_o = k == 14 ? 1'b0 : d[30 - k];
    end
  end
endmodule

// ==== verif/test_anh_host.sv ====
// Purpose: Self-checking bench for the auto-negotiation host
// Assumes: 25 MHz clock, PHY model on the management pins
// Notes: Clock enable held high throughout
`timescale 1ns/1ps
module test_anh_host;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic able = 1'b1;
  logic [4:0] adr = 5'h0;
  logic [31:0] wd = 32'h0;
  logic [15:0] base = 16'ha001;
  logic [31:0] q, acc, rdat;
  logic wreq, mdc, mo, moe, po, poe;
  wire mdio = moe ? mo : (poe ? po : 1'b1);
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  anh_host anh_host_i (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(1'b1), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .MDC_O(mdc), .MDIO_I(mdio), .MDIO_O(mo), .MDIO_OE_O(moe));
  anh_phy_model anh_phy_model_i (.mdc_i(mdc), .mdio_i(mdio), .able_i(able), .base_i(base),
    .mdio_o(po), .mdio_oe_o(poe));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] v);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= v;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Polls status until bit b reads v, gathering every bit seen meanwhile
  task automatic wait_st(input int b, input logic v);
    for (int i = 0; i < 5000; i++) begin
      bus(5'h0c, 1'b0, 32'h0);
      acc = acc | q;
      if (q[b] === v) break;
    end
  endtask
  task automatic t_regs();
    bus(5'h1c, 1'b1, 32'hffff_ffff);
    bus(5'h1c, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(5'h00, 1'b0, 32'h0);
    chk("start bit", 32'h0, {31'h0, q[5]});
    bus(5'h14, 1'b1, 32'h3);
    bus(5'h14, 1'b0, 32'h0);
    chk("phy address", 32'h3, q);
    $display("test regs done");
  endtask
  task automatic t_refuse();
    logic [31:0] bad [3] = '{32'h0800, 32'h0810, 32'h0005};
    foreach (bad[i]) begin
      bus(5'h08, 1'b1, bad[i]);
      bus(5'h0c, 1'b0, 32'h0);
      chk("refused page", 32'h2, {30'h0, q[5], q[3]});
    end
    $display("test refuse done");
  endtask
  task automatic t_run(input logic [31:0] ctl, input logic [15:0] exp);
    acc = 32'h0;
    bus(5'h00, 1'b1, ctl);
    wait_st(0, 1'b0);
    chk("phy control", {16'h0, exp}, {16'h0, anh_phy_model_i.r[0]});
  endtask
  task automatic t_np();
    acc = 32'h0;
    bus(5'h04, 1'b1, 32'h0821);
    bus(5'h00, 1'b1, 32'h39);
    // Page queued after start, since start drops the unformatted permission
    bus(5'h08, 1'b1, 32'h3805);
    wait_st(3, 1'b0);
    bus(5'h08, 1'b1, 32'h07ff);
    wait_st(0, 1'b0);
    chk("fault seen", 32'h1, {31'h0, acc[2]});
    chk("complete", 32'h1, {31'h0, q[1]});
    chk("advert", 32'ha821, {16'h0, anh_phy_model_i.r[4]});
    chk("pages", 32'h2, 32'(anh_phy_model_i.npg));
    chk("page 0", 32'hb005, {16'h0, anh_phy_model_i.pg[0]});
    chk("page 1", 32'h0fff, {16'h0, anh_phy_model_i.pg[1]});
    bus(5'h10, 1'b0, 32'h0);
    chk("partner page", 32'h6001, q);
    bus(5'h18, 1'b0, 32'h0);
    chk("partner base", 32'ha001, q);
    $display("test next page done");
  endtask
  task automatic t_manual();
    t_run(32'h26, 16'h2100);
    $display("test manual done");
  endtask
  task automatic t_null();
    bus(5'h04, 1'b1, 32'h0);
    t_run(32'h31, 16'h1000);
    // Fault still requested at the last completion stays held for this run
    chk("advert", 32'ha000, {16'h0, anh_phy_model_i.r[4]});
    chk("pages", 32'h1, 32'(anh_phy_model_i.npg));
    chk("null page", 32'h2801, {16'h0, anh_phy_model_i.pg[0]});
    $display("test null page done");
  endtask
  task automatic t_noable();
    able <= 1'b0;
    t_run(32'h21, 16'h1000);
    chk("able", 32'h0, {31'h0, q[6]});
    chk("fault dropped", 32'h0, {16'h0, anh_phy_model_i.r[4]});
    $display("test no ability done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_refuse();
    t_manual();
    t_np();
    t_null();
    t_noable();
    give_verdict();
  end
endmodule
